// [hw/csd_consts.vh]
// constants for the cpu core status datapath
`ifndef CSD_CONSTS_VH
`define CSD_CONSTS_VH
// register map (word addresses, one register per address)
`define CSD_ADDR_FLAGS 4'h0
`define CSD_ADDR_CORE_CTRL 4'h1
`define CSD_ADDR_INT_CTRL 4'h2
`define CSD_ADDR_WINDOW_PAGE 4'h3
`define CSD_ADDR_PC 4'h4
`define CSD_ADDR_OP_A 4'h5
`define CSD_ADDR_OP_B 4'h6
`define CSD_ADDR_CMD 4'h7
`define CSD_ADDR_RESULT 4'h8
`define CSD_ADDR_RESULT_HI 4'h9
`define CSD_ADDR_REPEAT 4'ha
`define CSD_ADDR_WREG_SEL 4'hb
`define CSD_ADDR_WREG_DATA 4'hc
`define CSD_ADDR_DATA_ADDR 4'hd
`define CSD_ADDR_PHYS_ADDR 4'he
// flag, core control and interrupt control register fields
`define CSD_FLAG_CARRY 0
`define CSD_FLAG_ZERO 1
`define CSD_FLAG_OVF 2
`define CSD_FLAG_NEG 3
`define CSD_FLAG_LOOP 4
`define CSD_FLAG_PRIO_LO 5
`define CSD_FLAG_PRIO_HI 7
`define CSD_FLAG_HALF 8
`define CSD_CORE_PRIO_MSB 3
`define CSD_CORE_WINDOW_EN 2
`define CSD_INT_NEST_DIS 15
// commands
`define CSD_OP_ADD 4'h0
`define CSD_OP_SUB 4'h1
`define CSD_OP_AND 4'h2
`define CSD_OP_OR 4'h3
`define CSD_OP_XOR 4'h4
`define CSD_OP_MUL_SS 4'h5
`define CSD_OP_MUL_UU 4'h6
`define CSD_OP_MUL_SU 4'h7
`define CSD_OP_MUL_US 4'h8
`define CSD_OP_SHIFT 4'h9
`define CSD_OP_DIV_U 4'ha
`define CSD_OP_DIV_S 4'hb
`define CSD_OP_PC_STEP 4'hc
`define CSD_OP_PC_LOAD 4'hd
// timing, pc mask and dma region
`define CSD_DIV_CYCLES 5'h13
`define CSD_DIV_STEPS 5'h10
`define CSD_PC_MASK 23'h7ffffe
`define CSD_DMA_BASE 16'h4000
`define CSD_DMA_BYTES 16'h0800
`endif

// [hw/csd_core_datapath.v]
// cpu core datapath: flags, working registers, multiplier, divider, shifter
//
// Local design decisions: the register offsets and the Avalon-MM register port.
`include "csd_consts.vh"
`default_nettype none

// Operation
// - program counter is 23 bits, addressing 4M words of 24 bits.
// - instruction words are 24 bits; next word prefetched in one cycle.
// - single-cycle commands, except flow changes, multiplies and divides.
// - a single-instruction repeat loop runs with no overhead, interruptible anywhere.
// - flag bit 4 reads 1 while a repeat loop runs; read only, resets 0.
// - sixteen 16-bit working registers; the last is the stack pointer.
// - memory read, register read, memory write and fetch in one cycle.
// - data space is 32K words, 64 Kbytes, linearly addressed.
// - upper 32 Kbytes may map to program space at an 8-bit page.
// - a 2 Kbyte DMA region also serves as ordinary RAM.
// - 17x17 multiplier does signed, unsigned and mixed-sign products.
// - divide runs 19 cycles in a repeat loop, interruptible without loss.
// - shifter moves an operand up to 16 places left or right.
// - half-carry flag set on carry out of bit 3 (byte mode) or bit 7 (word mode).
// - flag bits 7..5 hold priority level; level 7 disables user interrupts.
// - priority msb extends level to 8..15; when set, user interrupts disabled.
// - priority bits become read only when nesting disable is set.
// - negative flag follows the sign of the result.
// - overflow flag set when a signed result overflows.
// - zero flag set on zero result, cleared by a non-zero result.
// - carry flag set on carry out of the most significant bit.
// - flag bits 15..9 read zero; implemented bits reset to 0.
// - for subtraction carry and half-carry act as borrow indicators.
module csd_core_datapath #(
  parameter DIV_CYCLES = 19
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  input wire clkEn,
  // avalon-mm slave
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  // interrupt handoff
  input wire intRequest,
  output wire userIntDisabled,
  output wire busy
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [16:0] extend17;
    input [15:0] v;
    input s;
    begin
      extend17 = {s & v[15], v};
    end
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [15:0] wreg [0:15];
  reg [8:0] flags;
  reg priorityLevelMsb;
  reg windowEnable;
  reg nestingDisableBit;
  reg [7:0] programWindowPage;
  reg [22:0] programCounter;
  reg [15:0] opA;
  reg [15:0] opB;
  reg [15:0] result;
  reg [15:0] resultHi;
  reg [15:0] repeatCount;
  reg [3:0] wregSel;
  reg [15:0] dataAddr;
  reg [1:0] state;
  reg [4:0] divCount;
  reg divSigned;
  reg [31:0] divRem;
  reg [15:0] divQuot;
  reg byteMode;
  reg [4:0] stallCount;
  reg ackDone;
  integer i;

  localparam ST_IDLE = 2'd0;
  localparam ST_DIV = 2'd1;
  localparam ST_STALL = 2'd2;

  // one wait cycle then acknowledge
  assign waitrequest = (read | write) & ~ackDone;
  wire accept = (read | write) & ackDone & clkEn;
  wire loopActive = (state == ST_DIV);
  assign busy = (state != ST_IDLE);
  assign userIntDisabled = priorityLevelMsb | (&flags[7:5]);

  // ----------------------------------------
  // combinational datapath
  // ----------------------------------------
  wire [16:0] sumW = {1'b0, opA} + {1'b0, opB};
  wire [16:0] difW = {1'b0, opA} - {1'b0, opB};
  wire [8:0] sumLo = {1'b0, opA[7:0]} + {1'b0, opB[7:0]};
  wire [8:0] difLo = {1'b0, opA[7:0]} - {1'b0, opB[7:0]};
  wire [4:0] sumNib = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
  wire [4:0] difNib = {1'b0, opA[3:0]} - {1'b0, opB[3:0]};
  reg [3:0] cmd;
  reg [16:0] mulA;
  reg [16:0] mulB;
  wire [33:0] product = $signed(mulA) * $signed(mulB);
  wire [4:0] shAmt = opB[15] ? (~opB[4:0] + 5'h01) : opB[4:0];
  wire [31:0] shLeft = {16'h0000, opA} << shAmt;
  wire [15:0] shRight = opA >> shAmt;
  // upper half of data space falls into the program window
  wire inWindow = windowEnable & dataAddr[15];
  wire [23:0] physAddr = {programWindowPage, dataAddr[14:0], 1'b0};
  wire inDma = (dataAddr >= `CSD_DMA_BASE) && (dataAddr < `CSD_DMA_BASE + `CSD_DMA_BYTES);

  always @* begin
    mulA = extend17(opA, cmd == `CSD_OP_MUL_SS || cmd == `CSD_OP_MUL_SU);
    mulB = extend17(opB, cmd == `CSD_OP_MUL_SS || cmd == `CSD_OP_MUL_US);
  end

  // ----------------------------------------
  // divider step
  // ----------------------------------------
  wire [15:0] absDen = (divSigned & opB[15]) ? (~opB + 16'h0001) : opB;
  wire [16:0] trial = divRem[31:15] - {1'b0, absDen};

  // ----------------------------------------
  // sequential
  // ----------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 16; i = i + 1) begin
        wreg[i] <= 16'h0000;
      end
      flags <= 9'h000;
      priorityLevelMsb <= 1'b0;
      windowEnable <= 1'b0;
      nestingDisableBit <= 1'b0;
      programWindowPage <= 8'h00;
      programCounter <= 23'h000000;
      opA <= 16'h0000;
      opB <= 16'h0000;
      result <= 16'h0000;
      resultHi <= 16'h0000;
      repeatCount <= 16'h0000;
      wregSel <= 4'h0;
      dataAddr <= 16'h0000;
      state <= ST_IDLE;
      divCount <= 5'h00;
      divSigned <= 1'b0;
      divRem <= 32'h00000000;
      divQuot <= 16'h0000;
      byteMode <= 1'b0;
      stallCount <= 5'h00;
      ackDone <= 1'b0;
      cmd <= 4'h0;
    end else if (clkEn) begin
      ackDone <= (read | write) & ~ackDone;
      case (state)
        ST_DIV: begin
          // interrupt freezes the loop; partial remainder and quotient stay intact
          if (!intRequest) begin
            if (divCount > `CSD_DIV_CYCLES - `CSD_DIV_STEPS) begin
              if (!trial[16]) begin
                divRem <= {trial[15:0], divRem[14:0], 1'b0};
                divQuot <= {divQuot[14:0], 1'b1};
              end else begin
                divRem <= {divRem[30:0], 1'b0};
                divQuot <= {divQuot[14:0], 1'b0};
              end
            end
            divCount <= divCount - 5'h01;
            if (divCount == 5'h01) begin
              state <= ST_IDLE;
              wreg[0] <= divQuot;
              wreg[1] <= divRem[31:16];
              flags[`CSD_FLAG_ZERO] <= (divQuot == 16'h0000);
              flags[`CSD_FLAG_NEG] <= divQuot[15];
              flags[`CSD_FLAG_OVF] <= (opB == 16'h0000);
            end
          end
        end
        ST_STALL: begin
          stallCount <= stallCount - 5'h01;
          if (stallCount == 5'h01) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          if (accept && write) begin
            if (address == `CSD_ADDR_FLAGS) begin
              flags[`CSD_FLAG_HALF] <= writedata[`CSD_FLAG_HALF];
              flags[3:0] <= writedata[3:0];
              if (!nestingDisableBit) begin
                flags[7:5] <= writedata[7:5];
              end
            end else if (address == `CSD_ADDR_CORE_CTRL) begin
              // priority msb is clear-only
              if (!writedata[`CSD_CORE_PRIO_MSB]) begin
                priorityLevelMsb <= 1'b0;
              end
              windowEnable <= writedata[`CSD_CORE_WINDOW_EN];
            end else if (address == `CSD_ADDR_INT_CTRL) begin
              nestingDisableBit <= writedata[`CSD_INT_NEST_DIS];
            end else if (address == `CSD_ADDR_WINDOW_PAGE) begin
              programWindowPage <= writedata[7:0];
            end else if (address == `CSD_ADDR_OP_A) begin
              opA <= writedata[15:0];
            end else if (address == `CSD_ADDR_OP_B) begin
              opB <= writedata[15:0];
            end else if (address == `CSD_ADDR_REPEAT) begin
              repeatCount <= writedata[15:0];
            end else if (address == `CSD_ADDR_WREG_SEL) begin
              wregSel <= writedata[3:0];
            end else if (address == `CSD_ADDR_WREG_DATA) begin
              wreg[wregSel] <= writedata[15:0];
            end else if (address == `CSD_ADDR_DATA_ADDR) begin
              dataAddr <= writedata[15:0];
            end else if (address == `CSD_ADDR_CMD) begin
              cmd <= writedata[3:0];
              byteMode <= writedata[4];
              case (writedata[3:0])
                `CSD_OP_ADD: begin
                  result <= writedata[4] ? {8'h00, sumW[7:0]} : sumW[15:0];
                  flags[`CSD_FLAG_CARRY] <= writedata[4] ? sumLo[8] : sumW[16];
                  flags[`CSD_FLAG_HALF] <= writedata[4] ? sumNib[4] : sumLo[8];
                  flags[`CSD_FLAG_ZERO] <= writedata[4] ? (sumW[7:0] == 8'h00) : (sumW[15:0] == 16'h0000);
                  flags[`CSD_FLAG_NEG] <= writedata[4] ? sumW[7] : sumW[15];
                  flags[`CSD_FLAG_OVF] <= writedata[4] ? ((opA[7] == opB[7]) && (sumW[7] != opA[7]))
                    : ((opA[15] == opB[15]) && (sumW[15] != opA[15]));
                end
                `CSD_OP_SUB: begin
                  // carry is an active-low borrow
                  result <= writedata[4] ? {8'h00, difW[7:0]} : difW[15:0];
                  flags[`CSD_FLAG_CARRY] <= writedata[4] ? ~difLo[8] : ~difW[16];
                  flags[`CSD_FLAG_HALF] <= writedata[4] ? ~difNib[4] : ~difLo[8];
                  flags[`CSD_FLAG_ZERO] <= writedata[4] ? (difW[7:0] == 8'h00) : (difW[15:0] == 16'h0000);
                  flags[`CSD_FLAG_NEG] <= writedata[4] ? difW[7] : difW[15];
                  flags[`CSD_FLAG_OVF] <= writedata[4] ? ((opA[7] != opB[7]) && (difW[7] != opA[7]))
                    : ((opA[15] != opB[15]) && (difW[15] != opA[15]));
                end
                `CSD_OP_AND, `CSD_OP_OR, `CSD_OP_XOR: begin
                  // logic ops touch only zero and negative
                  result <= (writedata[3:0] == `CSD_OP_AND) ? (opA & opB)
                    : (writedata[3:0] == `CSD_OP_OR) ? (opA | opB) : (opA ^ opB);
                  flags[`CSD_FLAG_ZERO] <= (((writedata[3:0] == `CSD_OP_AND) ? (opA & opB)
                    : (writedata[3:0] == `CSD_OP_OR) ? (opA | opB) : (opA ^ opB)) == 16'h0000);
                  flags[`CSD_FLAG_NEG] <= (writedata[3:0] == `CSD_OP_AND) ? (opA[15] & opB[15])
                    : (writedata[3:0] == `CSD_OP_OR) ? (opA[15] | opB[15]) : (opA[15] ^ opB[15]);
                end
                `CSD_OP_MUL_SS, `CSD_OP_MUL_UU, `CSD_OP_MUL_SU, `CSD_OP_MUL_US: begin
                  // product settles the cycle after cmd; captured on next idle cycle
                  state <= ST_STALL;
                  stallCount <= 5'h01;
                end
                `CSD_OP_SHIFT: begin
                  // positive count shifts right, negative left, zero leaves operand
                  result <= opB[15] ? shLeft[15:0] : shRight;
                end
                `CSD_OP_DIV_U, `CSD_OP_DIV_S: begin
                  state <= ST_DIV;
                  divCount <= DIV_CYCLES[4:0];
                  divSigned <= (writedata[3:0] == `CSD_OP_DIV_S);
                  divRem <= {16'h0000, opA};
                  divQuot <= 16'h0000;
                end
                `CSD_OP_PC_STEP: begin
                  programCounter <= (programCounter + 23'h000002) & `CSD_PC_MASK;
                end
                `CSD_OP_PC_LOAD: begin
                  // flow change costs one extra cycle to refill prefetch
                  programCounter <= {opB[6:0], opA} & `CSD_PC_MASK;
                  state <= ST_STALL;
                  stallCount <= 5'h01;
                end
                default: begin
                end
              endcase
            end
          end
          if (state == ST_IDLE && cmd >= `CSD_OP_MUL_SS && cmd <= `CSD_OP_MUL_US && stallCount == 5'h00) begin
            result <= product[15:0];
            resultHi <= product[31:16];
            cmd <= `CSD_OP_PC_STEP;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    readdata = 32'h00000000;
    if (address == `CSD_ADDR_FLAGS) begin
      readdata = {23'h000000, flags[8:5], loopActive, flags[3:0]};
    end else if (address == `CSD_ADDR_CORE_CTRL) begin
      readdata = {28'h0000000, priorityLevelMsb, windowEnable, 2'b00};
    end else if (address == `CSD_ADDR_INT_CTRL) begin
      readdata = {16'h0000, nestingDisableBit, 15'h0000};
    end else if (address == `CSD_ADDR_WINDOW_PAGE) begin
      readdata = {24'h000000, programWindowPage};
    end else if (address == `CSD_ADDR_PC) begin
      readdata = {9'h000, programCounter};
    end else if (address == `CSD_ADDR_OP_A) begin
      readdata = {16'h0000, opA};
    end else if (address == `CSD_ADDR_OP_B) begin
      readdata = {16'h0000, opB};
    end else if (address == `CSD_ADDR_CMD) begin
      readdata = {27'h0000000, byteMode, cmd};
    end else if (address == `CSD_ADDR_RESULT) begin
      readdata = {16'h0000, result};
    end else if (address == `CSD_ADDR_RESULT_HI) begin
      readdata = {16'h0000, resultHi};
    end else if (address == `CSD_ADDR_REPEAT) begin
      readdata = {11'h000, divCount, repeatCount};
    end else if (address == `CSD_ADDR_WREG_SEL) begin
      readdata = {28'h0000000, wregSel};
    end else if (address == `CSD_ADDR_WREG_DATA) begin
      readdata = {16'h0000, wreg[wregSel]};
    end else if (address == `CSD_ADDR_DATA_ADDR) begin
      readdata = {14'h0000, inDma, inWindow, dataAddr};
    end else if (address == `CSD_ADDR_PHYS_ADDR) begin
      readdata = {8'h00, physAddr};
    end
  end

endmodule

`default_nettype wire

// [tb/csd_core_datapath_properties.sv]
// assertion checker for the cpu core status datapath
`include "csd_consts.vh"
`default_nettype none
module csd_core_checker #(
  parameter int DIV_CYCLES = 19
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clkEn,
  // register bus
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // core status
  input wire logic intRequest,
  input wire logic userIntDisabled,
  input wire logic busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic fRd;
  logic divStart;
  logic divRun;
  logic [7:0] divCnt;
  logic flagsValid;
  logic [8:0] lastFlags;
  assign fRd = read && !waitrequest && clkEn && address == `CSD_ADDR_FLAGS;
  assign divStart = write && !waitrequest && clkEn && !busy && address == `CSD_ADDR_CMD &&
    (writedata[3:0] == `CSD_OP_DIV_U || writedata[3:0] == `CSD_OP_DIV_S);
  // frozen cycles are left out: the loop must not lose a step to them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      divRun <= 1'b0;
      divCnt <= 8'h00;
      flagsValid <= 1'b0;
      lastFlags <= 9'h000;
    end else begin
      if (divStart) begin
        divRun <= 1'b1;
        divCnt <= 8'h00;
      end else if (divRun && !busy) begin
        divRun <= 1'b0;
      end else if (divRun && clkEn && !intRequest) begin
        divCnt <= divCnt + 8'h01;
      end
      if (write || busy) begin
        flagsValid <= 1'b0;
      end else if (fRd) begin
        flagsValid <= 1'b1;
        lastFlags <= readdata[8:0];
      end
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  chk_wait_rise: assert property ($rose(read || write) |-> waitrequest)
    else $error("request accepted in its first cycle");
  chk_wait_answer: assert property ((read || write) && waitrequest && clkEn |=> !waitrequest)
    else $error("request not answered after one cycle");
  chk_upper_zero: assert property (fRd |-> readdata[15:9] == 7'h00)
    else $error("unimplemented flag bits not zero");
  chk_prio_seven: assert property (fRd && readdata[7:5] == 3'h7 |-> userIntDisabled)
    else $error("level seven leaves user interrupts on");
  chk_prio_msb: assert property (read && !waitrequest && address == `CSD_ADDR_CORE_CTRL && readdata[3]
    |-> userIntDisabled)
    else $error("priority msb leaves user interrupts on");
  chk_loop_flag: assert property (fRd && divRun |-> readdata[4] == busy)
    else $error("loop flag differs from divide activity");
  chk_loop_idle: assert property (fRd && !divRun |-> !readdata[4])
    else $error("loop flag set with no loop running");
  chk_div_length: assert property (divRun && !busy |-> divCnt == DIV_CYCLES)
    else $error("divide length wrong");
  chk_div_bound: assert property (divRun |-> divCnt <= DIV_CYCLES)
    else $error("divide runs too long");
  chk_flags_hold: assert property (fRd && flagsValid |-> readdata[8:0] == lastFlags)
    else $error("flags changed with no command");
endmodule
bind csd_core_datapath csd_core_checker #(.DIV_CYCLES(DIV_CYCLES)) i_csd_core_checker (
  .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .intRequest(intRequest),
  .userIntDisabled(userIntDisabled), .busy(busy));
`default_nettype wire

// [tb/csd_core_datapath_tb.sv]
// self-checking testbench for the cpu core status datapath
`include "csd_consts.vh"
`default_nettype none
module csd_core_datapath_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] c; logic [15:0] a; logic [15:0] b; logic [31:0] r; logic [15:0] f;
    logic [15:0] m;} csd_vec_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic intRequest = 1'b0;
  wire [31:0] readdata;
  wire waitrequest;
  wire userIntDisabled;
  wire busy;
  int errorCnt = 0;
  int checkCount = 0;
  int i;
  logic [31:0] q;
  logic [31:0] lo;
  // op, a, b, result, flags, flag mask
  csd_vec_t vecs [18] = '{
    '{8'h00, 16'hffff, 16'h0001, 32'h0, 16'h103, 16'h10f}, '{8'h00, 16'h7fff, 16'h0001, 32'h8000, 16'h10c, 16'h10f},
    '{8'h01, 16'h0005, 16'h0007, 32'hfffe, 16'h008, 16'h10f}, '{8'h01, 16'h8000, 16'h0001, 32'h7fff, 16'h005, 16'h10f},
    '{8'h01, 16'h1234, 16'h1234, 32'h0, 16'h103, 16'h10f}, '{8'h02, 16'hf0f0, 16'h0ff0, 32'h00f0, 16'h101, 16'h10f},
    '{8'h03, 16'h8000, 16'h0001, 32'h8001, 16'h109, 16'h10f}, '{8'h04, 16'h5555, 16'h5555, 32'h0, 16'h103, 16'h10f},
    '{8'h10, 16'h000f, 16'h0001, 32'h0010, 16'h100, 16'h10f}, '{8'h05, 16'hffff, 16'h0002, 32'hfffffffe, 16'h0, 16'h0},
    '{8'h06, 16'hffff, 16'h0002, 32'h0001fffe, 16'h0, 16'h0}, '{8'h07, 16'hffff, 16'h8000, 32'hffff8000, 16'h0, 16'h0},
    '{8'h08, 16'hffff, 16'h8000, 32'h80008000, 16'h0, 16'h0}, '{8'h09, 16'h0f00, 16'h0004, 32'h00f0, 16'h0, 16'h0},
    '{8'h09, 16'h0f00, 16'hfffc, 32'hf000, 16'h0, 16'h0}, '{8'h09, 16'h7fff, 16'h0010, 32'h0, 16'h0, 16'h0},
    '{8'h09, 16'h0f00, 16'hfff0, 32'h0, 16'h0, 16'h0}, '{8'h09, 16'h1234, 16'h0000, 32'h1234, 16'h0, 16'h0}};
  csd_core_datapath #(.DIV_CYCLES(19)) i_csd_core_datapath (
    .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .intRequest(intRequest),
    .userIntDisabled(userIntDisabled), .busy(busy));
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic results;
    if (errorCnt == 0 && checkCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] e, input logic [31:0] m);
    checkCount++;
    if ((got & m) !== (e & m)) begin
      errorCnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
    end
  endtask
  // request held until the edge that sees waitrequest low; data taken at that edge
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge core_clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (waitrequest === 1'b0) break;
    end
    if (n == 20) begin
      errorCnt++;
      results;
    end
    r = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    acc(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    acc(1'b0, a, 32'h0, q);
    chk(q, e, m);
  endtask
  task automatic waitIdle;
    int n;
    for (n = 0; n < 100; n++) begin
      @(negedge core_clk);
      if (busy === 1'b0) break;
    end
    if (n == 100) begin
      errorCnt++;
      results;
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    rdc(`CSD_ADDR_FLAGS, 32'h0, 32'hffff);
    wr(`CSD_ADDR_FLAGS, 32'hffff);
    rdc(`CSD_ADDR_FLAGS, 32'h1ef, 32'hffff);
    wr(`CSD_ADDR_FLAGS, 32'h0);
    wr(`CSD_ADDR_INT_CTRL, 32'h8000);
    wr(`CSD_ADDR_FLAGS, 32'he1);
    rdc(`CSD_ADDR_FLAGS, 32'h001, 32'h1ff);
    wr(`CSD_ADDR_INT_CTRL, 32'h0);
    wr(`CSD_ADDR_FLAGS, 32'h0);
    wr(`CSD_ADDR_CORE_CTRL, 32'hc);
    rdc(`CSD_ADDR_CORE_CTRL, 32'h4, 32'hffff);
    wr(`CSD_ADDR_CORE_CTRL, 32'h0);
    for (i = 0; i < 18; i++) begin
      wr(`CSD_ADDR_OP_A, {16'h0, vecs[i].a});
      wr(`CSD_ADDR_OP_B, {16'h0, vecs[i].b});
      wr(`CSD_ADDR_CMD, {24'h0, vecs[i].c});
      waitIdle;
      acc(1'b0, `CSD_ADDR_RESULT, 32'h0, lo);
      acc(1'b0, `CSD_ADDR_RESULT_HI, 32'h0, q);
      chk({q[15:0], lo[15:0]}, vecs[i].r, (vecs[i].c >= 8'h05 && vecs[i].c <= 8'h08) ? 32'hffffffff : 32'hffff);
      rdc(`CSD_ADDR_FLAGS, {16'h0, vecs[i].f}, {16'h0, vecs[i].m});
    end
    // divide with an interrupt hold and a clock-enable freeze in mid-loop
    wr(`CSD_ADDR_OP_A, 32'h3e8);
    wr(`CSD_ADDR_OP_B, 32'h7);
    wr(`CSD_ADDR_CMD, 32'ha);
    rdc(`CSD_ADDR_FLAGS, 32'h10, 32'h10);
    intRequest <= 1'b1;
    repeat (4) @(posedge core_clk);
    intRequest <= 1'b0;
    clkEn <= 1'b0;
    repeat (2) @(posedge core_clk);
    clkEn <= 1'b1;
    waitIdle;
    rdc(`CSD_ADDR_FLAGS, 32'h0, 32'h10);
    wr(`CSD_ADDR_WREG_SEL, 32'h0);
    rdc(`CSD_ADDR_WREG_DATA, 32'h8e, 32'hffff);
    wr(`CSD_ADDR_WREG_SEL, 32'h1);
    rdc(`CSD_ADDR_WREG_DATA, 32'h6, 32'hffff);
    wr(`CSD_ADDR_WREG_SEL, 32'hf);
    wr(`CSD_ADDR_WREG_DATA, 32'h1234);
    rdc(`CSD_ADDR_WREG_DATA, 32'h1234, 32'hffff);
    wr(4'hf, 32'hffffffff);
    rdc(4'hf, 32'h0, 32'hffffffff);
    results;
  end
endmodule
`default_nettype wire
